// ===== core/tcm_timer.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module tcm_timer #(
	parameter int NUM_CH = tcm_pkg::NUM_CH
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [NUM_CH-1:0] channel_pin_in,
	output logic [NUM_CH-1:0]      channel_pin_out,
	output logic [NUM_CH-1:0]      channel_pin_oe,
	output logic                   irq
);
	localparam int W = tcm_pkg::CNT_W;
	localparam int SW = NUM_CH + 1;

	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]        mod_hi_q;
	logic [7:0]        mod_lo_q;
	logic              mod_hold_q;
	logic [7:0]        ctrl_q;
	logic [W-1:0]      count_q;
	logic [7:0]        ch_ctrl_q [NUM_CH];
	logic [W-1:0]      cmp_q [NUM_CH];
	logic [SW-1:0]     stat_q;
	logic [SW-1:0]     mask_q;

	// pin synchroniser and channel events
	logic [NUM_CH-1:0] pin_s1_q;
	logic [NUM_CH-1:0] pin_s2_q;
	logic [NUM_CH-1:0] ch_ev;

	// write channel holding registers
	logic              aw_full_q;
	logic              w_full_q;
	logic [7:0]        aw_q;
	logic [31:0]       wd_q;
	logic [3:0]        ws_q;

	////////////////////////////////////////////////////////////////////
	// axi write: address and data caught in either order
	// one write in flight: the response is taken before the next one lands
	logic ch_wr_hit;
	logic cmp_wr_hit;
	wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
	wire wr_lane = do_wr && ws_q[0];
	wire [7:0] wb = wd_q[7:0];
	wire wr_hi   = wr_lane && aw_q == tcm_pkg::ADDR_MOD_HI;
	wire wr_lo   = wr_lane && aw_q == tcm_pkg::ADDR_MOD_LO;
	wire wr_ctrl = wr_lane && aw_q == tcm_pkg::ADDR_CTRL;
	wire wr_stat = wr_lane && aw_q == tcm_pkg::ADDR_STATUS;
	wire wr_mask = wr_lane && aw_q == tcm_pkg::ADDR_MASK;
	wire wr_ok = (aw_q == tcm_pkg::ADDR_MOD_HI) || (aw_q == tcm_pkg::ADDR_MOD_LO)
		|| (aw_q == tcm_pkg::ADDR_CTRL) || (aw_q == tcm_pkg::ADDR_STATUS)
		|| (aw_q == tcm_pkg::ADDR_MASK) || (aw_q == tcm_pkg::ADDR_COUNT)
		|| ch_wr_hit || cmp_wr_hit;
	// readies are flops mirroring the full flags, so every port leaves a register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			aw_q         <= 8'h00;
			wd_q         <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tcm_pkg::RESP_OK;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? tcm_pkg::RESP_OK : tcm_pkg::RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// counter and modulo
	wire [W-1:0] modulo = {mod_hi_q, mod_lo_q};
	wire stop   = ctrl_q[tcm_pkg::F_STOP];
	wire crst   = ctrl_q[tcm_pkg::F_RST];
	// compare and overflow are blind while stopped or held in reset
	wire at_mod = !stop && !crst && count_q == modulo;
	// the hold keeps a half-written modulo from flagging a bogus wrap
	wire ovf_ev = at_mod && !mod_hold_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mod_hi_q   <= tcm_pkg::MOD_RESET;
			mod_lo_q   <= tcm_pkg::MOD_RESET;
			mod_hold_q <= 1'b0;
			ctrl_q     <= tcm_pkg::CTRL_RESET;
			count_q    <= '0;
		end else begin
			if (wr_hi) begin
				mod_hi_q   <= wb;
				mod_hold_q <= 1'b1;
			end
			if (wr_lo) begin
				mod_lo_q   <= wb;
				mod_hold_q <= 1'b0;
			end
			// counter reset bit self-clears after one cycle
			if (wr_ctrl) begin
				ctrl_q <= wb;
			end else begin
				ctrl_q[tcm_pkg::F_RST] <= 1'b0;
			end
			if (crst) begin
				count_q <= '0;
			end else if (at_mod) begin
				count_q <= '0;
			end else if (!stop) begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// channels
	logic [NUM_CH-1:0] ch_wr_sel;
	logic [NUM_CH-1:0] cmp_wr_sel;
	logic [NUM_CH-1:0] ch_rd_sel;
	logic [NUM_CH-1:0] cmp_rd_sel;
	assign ch_wr_hit  = |ch_wr_sel;
	assign cmp_wr_hit = |cmp_wr_sel;

	// buffered modes act on the one compare register: no shadow copy
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			localparam logic [7:0] CA = 8'(tcm_pkg::ADDR_CH_BASE + g * tcm_pkg::ADDR_CH_STEP);
			localparam logic [7:0] PA = 8'(tcm_pkg::ADDR_CMP_BASE + g * tcm_pkg::ADDR_CH_STEP);
			assign ch_wr_sel[g]  = aw_q == CA;
			assign cmp_wr_sel[g] = aw_q == PA;
			assign ch_rd_sel[g]  = s_axi_araddr == CA;
			assign cmp_rd_sel[g] = s_axi_araddr == PA;
			wire wr_c = wr_lane && ch_wr_sel[g];
			wire wr_p = do_wr && cmp_wr_sel[g];
			wire hit = !stop && !crst && count_q == cmp_q[g];

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ch_ctrl_q[g] <= tcm_pkg::CH_RESET;
					cmp_q[g]     <= '0;
				end else begin
					if (wr_c) begin
						ch_ctrl_q[g][tcm_pkg::F_IE:0] <= wb[tcm_pkg::F_IE:0];
					end
					// flag: writing zero clears, but an event wins
					if (ch_ev[g]) begin
						ch_ctrl_q[g][tcm_pkg::F_FLG] <= 1'b1;
					end else if (wr_c && !wb[tcm_pkg::F_FLG]) begin
						ch_ctrl_q[g][tcm_pkg::F_FLG] <= 1'b0;
					end
					if (wr_p) begin
						cmp_q[g] <= wd_q[W-1:0];
					end
				end
			end
			tcm_channel u_ch (
				.aclk        (aclk),
				.aresetn     (aresetn),
				.ctrl        (ch_ctrl_q[g]),
				.compare_hit (hit),
				.overflow    (ovf_ev),
				.pin_in_s    (pin_s2_q[g]),
				.event_p     (ch_ev[g]),
				.pin_out     (channel_pin_out[g]),
				.pin_oe      (channel_pin_oe[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// pin sync, status, mask, irq
	wire [SW-1:0] ev_vec = {ch_ev, ovf_ev};
	wire [SW-1:0] ie_vec;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ie
			assign ie_vec[g+1] = ch_ctrl_q[g][tcm_pkg::F_IE];
		end
	endgenerate
	// overflow has no enable of its own; its mask bit alone gates it
	assign ie_vec[tcm_pkg::ST_OVF] = 1'b1;
	// write one to clear; an event in the same cycle keeps its bit
	wire [SW-1:0] clr_vec = wr_stat ? wb[SW-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			stat_q   <= '0;
			mask_q   <= '0;
			irq      <= 1'b0;
		end else begin
			pin_s1_q <= channel_pin_in;
			pin_s2_q <= pin_s1_q;
			stat_q   <= (stat_q & ~clr_vec) | ev_vec; // set wins
			if (wr_mask) begin
				mask_q <= wb[SW-1:0];
			end
			irq <= |(stat_q & mask_q & ie_vec);
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi read
	// unmapped reads answer with an error and zero data
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr)
			tcm_pkg::ADDR_MOD_HI: rd_mux[7:0] = mod_hi_q;
			tcm_pkg::ADDR_MOD_LO: rd_mux[7:0] = mod_lo_q;
			tcm_pkg::ADDR_CTRL:   rd_mux[7:0] = ctrl_q;
			tcm_pkg::ADDR_COUNT:  rd_mux[W-1:0] = count_q;
			tcm_pkg::ADDR_STATUS: rd_mux[SW-1:0] = stat_q;
			tcm_pkg::ADDR_MASK:   rd_mux[SW-1:0] = mask_q;
			default: begin
				rd_ok = 1'b0;
				for (int i = 0; i < NUM_CH; i++) begin
					if (ch_rd_sel[i]) begin
						rd_mux[7:0] = ch_ctrl_q[i];
						rd_ok = 1'b1;
					end
					if (cmp_rd_sel[i]) begin
						rd_mux[W-1:0] = cmp_q[i];
						rd_ok = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= tcm_pkg::RESP_OK;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? tcm_pkg::RESP_OK : tcm_pkg::RESP_ERR;
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			// one read in flight: arready stays low until the data is taken
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// ===== pkg/tcm_pkg.sv
package tcm_pkg;
	localparam int CNT_W = 16;
	localparam int NUM_CH = 2;
	// register byte addresses
	localparam logic [7:0] ADDR_MOD_HI  = 8'h00;
	localparam logic [7:0] ADDR_MOD_LO  = 8'h04;
	localparam logic [7:0] ADDR_CTRL    = 8'h08;
	localparam logic [7:0] ADDR_COUNT   = 8'h0c;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_MASK    = 8'h14;
	localparam logic [7:0] ADDR_CH_BASE = 8'h20;
	localparam logic [7:0] ADDR_CH_STEP = 8'h04;
	localparam logic [7:0] ADDR_CMP_BASE = 8'h40;
	// channel control field positions
	localparam int F_TOV = 0;
	localparam int F_ELA = 2;
	localparam int F_ELB = 3;
	localparam int F_MSA = 4;
	localparam int F_MSB = 5;
	localparam int F_IE  = 6;
	localparam int F_FLG = 7;
	// timer control positions
	localparam int F_RST  = 4;
	localparam int F_STOP = 5;
	// status bit positions: bit0 overflow, bit1+ch channel
	localparam int ST_OVF = 0;
	localparam int ST_W = NUM_CH + 1;
	localparam logic [7:0] MOD_RESET = 8'hff;
	localparam logic [7:0] CH_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

// ===== core/tcm_channel.sv
`timescale 1ns/10ps
module tcm_channel (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] ctrl,
	input  wire logic       compare_hit,
	input  wire logic       overflow,
	input  wire logic       pin_in_s,
	output logic            event_p,
	output logic            pin_out,
	output logic            pin_oe
);
	logic pin_prev_q;
	logic out_q;
	logic out_d;
	wire  msb  = ctrl[tcm_pkg::F_MSB];
	wire  msa  = ctrl[tcm_pkg::F_MSA];
	wire  [1:0] els = {ctrl[tcm_pkg::F_ELB], ctrl[tcm_pkg::F_ELA]};
	wire  is_cap   = !msb && !msa;
	wire  detached = (els == 2'b00);
	wire  rise = pin_in_s && !pin_prev_q;
	wire  fall = !pin_in_s && pin_prev_q;
	// capture edge per code
	wire  cap_ev = is_cap && ((els[0] && rise) || (els[1] && fall));
	wire  cmp_ev = !is_cap && compare_hit;
	wire  tog = !is_cap && ctrl[tcm_pkg::F_TOV] && overflow;
	always_comb begin
		out_d = out_q;
		if (detached) begin
			out_d = !msa; // preset level
		end else if (!is_cap) begin
			if (cmp_ev) begin
				unique case (els)
					2'b01: out_d = !out_q;
					2'b10: out_d = 1'b0;
					2'b11: out_d = 1'b1;
					default: out_d = out_q;
				endcase
			end
			if (tog) begin
				out_d = !out_d;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_prev_q <= 1'b0;
			out_q      <= 1'b1;
			event_p    <= 1'b0;
			pin_out    <= 1'b1;
			pin_oe     <= 1'b0;
		end else begin
			pin_prev_q <= pin_in_s;
			out_q      <= out_d;
			event_p    <= cap_ev || cmp_ev;
			pin_out    <= out_d;
			pin_oe     <= !detached && !is_cap;
		end
	end
endmodule

// ===== tb/tcm_pin_model.sv
`timescale 1ns/10ps
module tcm_pin_model #(
	parameter int N = 2
) (
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	input  wire logic [N-1:0] ext_lvl,
	output logic      [N-1:0] pin_in
);
	// channel drive wins while enabled, else the outside source owns the wire
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// ===== tb/tcm_sva.sv
`timescale 1ns/10ps
module tcm_sva #(
	parameter int NUM_CH = 2
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [7:0]        s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [NUM_CH-1:0] channel_pin_out,
	input wire logic [NUM_CH-1:0] channel_pin_oe,
	input wire logic              irq
);
	logic [7:0] adr_q;
	logic [7:0] dat_q;
	// shadow of the last write, so pin effects can be tied to their control word
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[7:0];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	sequence s_ctl;
		$rose(s_axi_bvalid) && adr_q[7:3] == 5'h04;
	endsequence
	a_reset_quiet: assert property (!$past(aresetn) |-> !irq && !(|channel_pin_oe))
		else $error("outputs busy after reset");
	a_free_pin: assert property (s_ctl ##0 dat_q[3:2] == 2'h0 |-> ##[1:3] !channel_pin_oe[adr_q[2]])
		else $error("pin driven with edge bits clear");
	a_capture_input: assert property (s_ctl ##0 (dat_q[5:4] == 2'h0 && dat_q[3:2] != 2'h0)
		|-> ##[1:3] !channel_pin_oe[adr_q[2]])
		else $error("capture channel drives pin");
	a_compare_drives: assert property (s_ctl ##0 (dat_q[5:4] != 2'h0 && dat_q[3:2] != 2'h0)
		|-> ##[1:3] channel_pin_oe[adr_q[2]])
		else $error("compare channel not driving");
	a_preset_level: assert property (s_ctl ##0 dat_q[3:2] == 2'h0
		|-> ##[1:3] channel_pin_out[adr_q[2]] == !dat_q[4])
		else $error("wrong preset level");
	a_oe_by_write: assert property ($changed(channel_pin_oe)
		|-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("pin enable changed without write");
	a_irq_fall_write: assert property ($fell(irq)
		|-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("irq dropped without write");
	a_mask_off: assert property ($rose(s_axi_bvalid) && adr_q == tcm_pkg::ADDR_MASK
		&& dat_q[2:0] == 3'h0 |-> ##[1:3] !irq)
		else $error("irq high with all masked");
	c_capture: cover property (s_ctl ##0 (dat_q[5:4] == 2'h0 && dat_q[3:2] != 2'h0));
	c_compare: cover property (s_ctl ##0 (dat_q[5:4] != 2'h0 && dat_q[3:2] != 2'h0));
	c_irq: cover property ($rose(irq));
endmodule

// ===== tb/tcm_timer_test.sv
`timescale 1ns/10ps
module tcm_timer_test;
	localparam int N = tcm_pkg::NUM_CH;
	localparam logic [7:0] CH1 = tcm_pkg::ADDR_CH_BASE + tcm_pkg::ADDR_CH_STEP;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, p;
	logic [7:0]   s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, m;
	logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h15377, rng, rdat;
	logic [3:0]   s_axi_wstrb = 4'hf;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rrsp, wrsp;
	logic [N-1:0] channel_pin_in, channel_pin_out, channel_pin_oe, ext_lvl = '0;
	int           tests_run, miscompares;
	tcm_timer tcm_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_pin_in, .channel_pin_out,
		.channel_pin_oe, .irq);
	tcm_pin_model #(.N(N)) tcm_pin_model_i (.pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
		.ext_lvl(ext_lvl), .pin_in(channel_pin_in));
	always #2 aclk = ~aclk;
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic pin_exp(input logic [1:0] els, input logic prev);
		return (els == 2'h0) ? prev : (els == 2'h1) ? !prev : els[0];
	endfunction
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// readiness is looked at mid-cycle; the transfer happens at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(negedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		wrsp = s_axi_bresp;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = tcm_pkg::RESP_OK);
		rd(a, rdat, rrsp);
		chk({rrsp, rdat}, {er, e});
	endtask
	task automatic settle();
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(tcm_pkg::ADDR_MOD_HI, 32'hff);
		rchk(tcm_pkg::ADDR_MOD_LO, 32'hff);
		rchk(tcm_pkg::ADDR_CH_BASE, 32'h0);
		rchk(8'hfc, 32'h0, tcm_pkg::RESP_ERR);
		wr(8'hfc, 32'h0);
		chk(wrsp, tcm_pkg::RESP_ERR);
		wr(tcm_pkg::ADDR_MASK, 32'h0);
		chk(wrsp, tcm_pkg::RESP_OK);
		rng = rnd();
		m = {4'h0, rng[3:0]} + 8'h08;
		wr(tcm_pkg::ADDR_CTRL, 32'h30);
		wr(tcm_pkg::ADDR_MOD_HI, 32'h0);
		wr(tcm_pkg::ADDR_MOD_LO, {24'h0, m});
		rchk(tcm_pkg::ADDR_COUNT, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(tcm_pkg::ADDR_CTRL, 32'h0);
			if (i == 1) wr(tcm_pkg::ADDR_MOD_HI, 32'h0);
			if (i == 2) wr(tcm_pkg::ADDR_MOD_LO, {24'h0, m});
			wr(tcm_pkg::ADDR_STATUS, 32'h7);
			repeat (40) @(posedge aclk);
			rd(tcm_pkg::ADDR_STATUS, rdat, rrsp);
			chk(rdat[0], i != 1);
		end
		wr(tcm_pkg::ADDR_CTRL, 32'h20);
		rd(tcm_pkg::ADDR_COUNT, rdat, rrsp);
		chk(rdat <= m, 1'b1);
		rchk(tcm_pkg::ADDR_COUNT, rdat);
		for (int j = 0; j < 4; j++) begin
			wr(j == 3 ? tcm_pkg::ADDR_STATUS : tcm_pkg::ADDR_MASK, {31'h0, j != 1});
			settle();
			chk(irq, !j[0]);
		end
		for (int b = 0; b < 2; b++) begin
			wr(tcm_pkg::ADDR_CH_BASE, {27'h0, b[0], 4'h0});
			settle();
			chk({channel_pin_oe[0], channel_pin_out[0]}, {1'b0, !b[0]});
		end
		wr(tcm_pkg::ADDR_CTRL, 32'h30);
		wr(tcm_pkg::ADDR_MOD_HI, 32'h2);
		wr(tcm_pkg::ADDR_MOD_LO, 32'h0);
		// one compare per pass: compare point far below the 0x200 wrap
		for (int k = 1; k < 3; k++) for (int e = k - 1; e < 4; e++) begin
			wr(tcm_pkg::ADDR_CTRL, 32'h30);
			wr(tcm_pkg::ADDR_CH_BASE, {26'h0, k[1:0], e[1:0], 2'h0});
			rng = rnd();
			wr(tcm_pkg::ADDR_CMP_BASE, {24'h0, 8'h20 + {2'h0, rng[5:0]}});
			@(negedge aclk);
			p = channel_pin_out[0];
			wr(tcm_pkg::ADDR_CTRL, 32'h0);
			repeat (160) @(posedge aclk);
			wr(tcm_pkg::ADDR_CTRL, 32'h20);
			@(negedge aclk);
			chk(channel_pin_out[0], pin_exp(e[1:0], p));
			rchk(tcm_pkg::ADDR_CH_BASE, {24'h0, 2'h2, k[1:0], e[1:0], 2'h0});
		end
		wr(tcm_pkg::ADDR_CTRL, 32'h30);
		wr(tcm_pkg::ADDR_MOD_HI, 32'h0);
		wr(tcm_pkg::ADDR_MOD_LO, 32'h40);
		wr(tcm_pkg::ADDR_CH_BASE, 32'h15);
		wr(tcm_pkg::ADDR_CMP_BASE, 32'hffff);
		@(negedge aclk);
		p = channel_pin_out[0];
		wr(tcm_pkg::ADDR_CTRL, 32'h0);
		repeat (90) @(posedge aclk);
		wr(tcm_pkg::ADDR_CTRL, 32'h20);
		@(negedge aclk);
		chk(channel_pin_out[0], !p);
		for (int e = 1; e < 4; e++) for (int f = 0; f < 2; f++) begin
			wr(CH1, {26'h0, e[1:0], 2'h1});
			@(posedge aclk);
			ext_lvl[1] <= !f[0];
			repeat (8) @(posedge aclk);
			rchk(CH1, {24'h0, e[f], 3'h0, e[1:0], 2'h1});
		end
		// channel 1 status bit is still set from the captures; only its enable gates irq
		wr(tcm_pkg::ADDR_MASK, 32'h4);
		settle();
		chk(irq, 1'b0);
		wr(CH1, 32'h44);
		settle();
		chk(irq, 1'b1);
		final_report();
	end
endmodule
bind tcm_timer tcm_sva #(.NUM_CH(NUM_CH)) tcm_sva_i (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.s_axi_awaddr    (s_axi_awaddr),
	.s_axi_awvalid   (s_axi_awvalid),
	.s_axi_awready   (s_axi_awready),
	.s_axi_wdata     (s_axi_wdata),
	.s_axi_wvalid    (s_axi_wvalid),
	.s_axi_wready    (s_axi_wready),
	.s_axi_bvalid    (s_axi_bvalid),
	.channel_pin_out (channel_pin_out),
	.channel_pin_oe  (channel_pin_oe),
	.irq             (irq)
);
